/* hw/zvp_card_port.sv */
// card-side driver of the zoomed video port: pixels, syncs, i2s audio, i/o window
`timescale 1ns/1ps
// Summary of operation
// - one-way dedicated link card to graphics controller, no buffering or arbitration
// - card delivers already digitized video as yuv 4:2:2
// - card drives pixel clock timing every luma and chroma transfer
// - card drives line reference marking horizontal line timing
// - card drives frame sync marking frame boundaries
// - sixteen data lines: eight luma, eight chroma, driven toward the port
// - each four luma samples carry two cr and two cb samples
// - port meanings apply only in multimedia mode, else lines keep card meaning
// - multimedia mode limits host access to 32 sixteen-bit i/o ports
// - multimedia mode: no response to memory-mapped accesses
// - low five address lines stay for ordinary register access
// - two freed address lines reserved, left unconnected and undriven
// - card supplies i2s audio: lr select, data, bit clock, master clock
// - audio channel select distinguishes left bits from right bits
// - audio sample rate programmable to 32, 44.1 or 48 khz
module zvp_card_port (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic mm_mode_in,
  input wire logic [7:0] luma_in,
  input wire logic [7:0] cb_in,
  input wire logic [7:0] cr_in,
  input wire logic [1:0] rate_sel_in,
  input wire logic [15:0] audio_left_in,
  input wire logic [15:0] audio_right_in,
  input wire logic io_strobe_in,
  input wire logic io_mem_in,
  input wire logic [4:0] io_addr_in,
  output logic pixel_clock_out,
  output logic line_reference_out,
  output logic frame_sync_out,
  output logic [7:0] luma_out,
  output logic [7:0] chroma_out,
  output logic video_oe_out,
  output logic pixel_take_out,
  output logic i2s_lr_out,
  output logic i2s_data_out,
  output logic i2s_bit_clock_out,
  output logic i2s_master_clock_out,
  output logic audio_take_out,
  output logic reserved_line_hi_out,
  output logic reserved_line_hi_oe_out,
  output logic reserved_line_lo_out,
  output logic reserved_line_lo_oe_out,
  output logic io_hit_out,
  output logic [4:0] io_port_out
);
  import zvp_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ZVP_PIX_PH_W-1:0] ph;
    logic pclk;
    logic [9:0] h;
    logic [9:0] v;
    logic lref;
    logic fsync;
    logic [7:0] luma;
    logic [7:0] chroma;
    logic oe;
    logic pix_take;
    logic [ZVP_ACC_W-1:0] acc;
    logic [8:0] ac;
    logic lr;
    logic adata;
    logic [15:0] shl;
    logic [15:0] shr;
    logic aud_take;
    logic [6:0] io_s1;
    logic [6:0] io_s2;
    logic io_hit;
    logic [4:0] io_port;
    logic [1:0] rsv;
  } zvp_state_t;

  zvp_state_t st_q;
  zvp_state_t st_d;

  // picks the i2s bit for a slot: msb one slot after the lr change
  function automatic logic zvp_aud_bit(input logic [15:0] word, input logic [4:0] slot);
    logic [4:0] pos;
    pos = 5'(ZVP_AUD_BITS - slot);
    if (slot >= 5'h01 && slot <= ZVP_AUD_BITS) begin
      return word[pos[3:0]];
    end
    return 1'b0;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [ZVP_ACC_W:0] acc_sum;
  logic [ZVP_ACC_W-1:0] acc_inc;
  logic [8:0] nac;
  logic [9:0] nh;
  logic [9:0] nv;
  logic act;

  always_comb begin
    st_d = st_q;
    st_d.pix_take = 1'b0;
    st_d.aud_take = 1'b0;
    st_d.rsv = 2'h0; // reserved lines never driven
    st_d.oe = mm_mode_in; // port drivers only in multimedia mode
    nh = st_q.h;
    nv = st_q.v;
    act = 1'b0;
    // pixel clock divider and raster
    st_d.ph = st_q.ph + 1'b1;
    st_d.pclk = st_d.ph[ZVP_PIX_PH_W-1];
    if (st_q.ph == '1) begin
      nh = st_q.h + 10'h001;
      if (nh == ZVP_H_TOTAL) begin
        nh = 10'h000;
        nv = st_q.v + 10'h001;
        if (nv == ZVP_V_TOTAL) begin
          nv = 10'h000;
        end
      end
      act = (nh < ZVP_H_ACTIVE) && (nv >= ZVP_V_START) && (nv < 10'(ZVP_V_START + ZVP_V_ACTIVE));
      st_d.h = nh;
      st_d.v = nv;
      st_d.lref = act;
      st_d.fsync = (nv < ZVP_VS_LINES);
      // new pixel on the falling pclk edge, stable at the rising one
      if (act) begin
        st_d.luma = luma_in;
        st_d.chroma = nh[0] ? cr_in : cb_in; // cb, cr alternate per pixel
        st_d.pix_take = 1'b1;
      end else begin
        st_d.luma = ZVP_BLANK;
        st_d.chroma = ZVP_BLANK;
      end
    end
    // audio rate select
    case (rate_sel_in)
      ZVP_RATE_32K: acc_inc = ZVP_INC_32K;
      ZVP_RATE_44K: acc_inc = ZVP_INC_44K;
      ZVP_RATE_48K: acc_inc = ZVP_INC_48K;
      default: acc_inc = ZVP_INC_48K;
    endcase
    acc_sum = {1'b0, st_q.acc} + {1'b0, acc_inc};
    st_d.acc = acc_sum[ZVP_ACC_W-1:0];
    nac = st_q.ac;
    if (acc_sum[ZVP_ACC_W]) begin
      nac = st_q.ac + 9'h001;
      // data and lr move only on the falling bit clock
      if (st_q.ac[2:0] == 3'h7) begin
        if (nac == 9'h000) begin
          st_d.shl = audio_left_in;
          st_d.shr = audio_right_in;
          st_d.aud_take = 1'b1;
        end
        st_d.lr = nac[8];
        st_d.adata = zvp_aud_bit(nac[8] ? st_d.shr : st_d.shl, nac[7:3]);
      end
    end
    st_d.ac = nac;
    // video and audio idle outside multimedia mode
    if (!mm_mode_in) begin
      st_d.ph = '0;
      st_d.pclk = 1'b0;
      st_d.h = 10'h000;
      st_d.v = 10'h000;
      st_d.lref = 1'b0;
      st_d.fsync = 1'b0;
      st_d.luma = ZVP_BLANK;
      st_d.chroma = ZVP_BLANK;
      st_d.pix_take = 1'b0;
      st_d.ac = 9'h000;
      st_d.acc = '0;
      st_d.lr = 1'b0;
      st_d.adata = 1'b0;
      st_d.aud_take = 1'b0;
    end
    // host adapter pins pass two flops first
    st_d.io_s1 = {io_strobe_in, io_mem_in, io_addr_in};
    st_d.io_s2 = st_q.io_s1;
    // i/o window only, memory cycles ignored
    st_d.io_hit = mm_mode_in && st_q.io_s2[6] && !st_q.io_s2[5] && ({1'b0, st_q.io_s2[4:0]} < ZVP_IO_PORTS);
    st_d.io_port = st_q.io_s2[4:0];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign pixel_clock_out = st_q.pclk;
  assign line_reference_out = st_q.lref;
  assign frame_sync_out = st_q.fsync;
  assign luma_out = st_q.luma;
  assign chroma_out = st_q.chroma;
  assign video_oe_out = st_q.oe;
  assign pixel_take_out = st_q.pix_take;
  assign i2s_lr_out = st_q.lr;
  assign i2s_data_out = st_q.adata;
  assign i2s_bit_clock_out = st_q.ac[2];
  assign i2s_master_clock_out = st_q.ac[0];
  assign audio_take_out = st_q.aud_take;
  assign reserved_line_hi_out = st_q.rsv[1];
  assign reserved_line_hi_oe_out = st_q.rsv[1];
  assign reserved_line_lo_out = st_q.rsv[0];
  assign reserved_line_lo_oe_out = st_q.rsv[0];
  assign io_hit_out = st_q.io_hit;
  assign io_port_out = st_q.io_port;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb_main @(posedge clock_in); endclocking
  default disable iff (rst_in);

  property p_pclk_period;
    $rose(pixel_clock_out) && video_oe_out |-> ##4 ($rose(pixel_clock_out) || !video_oe_out);
  endproperty
  a_pclk_period: assert property (p_pclk_period) else $error("pixel clock period not four cycles");

  property p_data_stable;
    $rose(pixel_clock_out) |-> $stable(luma_out) && $stable(chroma_out) && $stable(line_reference_out);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("pixel data moved on rising pixel clock");

  property p_blank;
    !line_reference_out |-> luma_out == ZVP_BLANK && chroma_out == ZVP_BLANK;
  endproperty
  a_blank: assert property (p_blank) else $error("data outside line reference");

  property p_sync_apart;
    frame_sync_out |-> !line_reference_out;
  endproperty
  a_sync_apart: assert property (p_sync_apart) else $error("active line during frame sync");

  property p_reserved;
    !reserved_line_hi_oe_out && !reserved_line_lo_oe_out;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved line driven");

  property p_no_mem;
    io_hit_out |-> $past(io_strobe_in, 3) && !$past(io_mem_in, 3) && io_port_out == $past(io_addr_in, 3);
  endproperty
  a_no_mem: assert property (p_no_mem) else $error("i/o hit without i/o strobe");

  property p_lr_edge;
    $changed(i2s_lr_out) && video_oe_out |-> $fell(i2s_bit_clock_out) && $fell(i2s_master_clock_out);
  endproperty
  a_lr_edge: assert property (p_lr_edge) else $error("lr select moved off falling bit clock");

  property p_data_edge;
    $changed(i2s_data_out) && video_oe_out |-> $fell(i2s_bit_clock_out);
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("audio data moved off falling bit clock");

  // taken pixel shows the luma and the cb or cr sample picked by pixel parity
  property p_chroma_alt;
    pixel_take_out |-> luma_out == $past(luma_in) && chroma_out == (st_q.h[0] ? $past(cr_in) : $past(cb_in));
  endproperty
  a_chroma_alt: assert property (p_chroma_alt) else $error("chroma sample not alternating cb and cr");

  property p_off_idle;
    !video_oe_out |=> !line_reference_out && !pixel_clock_out;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("port active outside multimedia mode");

  c_line: cover property ($rose(line_reference_out));
  c_frame: cover property ($rose(frame_sync_out));
  c_audio: cover property (audio_take_out);
  c_io: cover property (io_hit_out);
endmodule // zvp_card_port

/* hw/zvp_pkg.sv */
// constants for the zoomed video card-side port driver
package zvp_pkg;
  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam longint ZVP_CLK_HZ = 40000000;
  localparam int ZVP_PIX_PH_W = 2; // pixel clock = clock_in / 4
  // ----------------------------------------------------------------
  // video raster (small defaults, in pixel clocks and lines)
  // ----------------------------------------------------------------
  localparam logic [9:0] ZVP_H_TOTAL = 10'h020;
  localparam logic [9:0] ZVP_H_ACTIVE = 10'h018;
  localparam logic [9:0] ZVP_V_TOTAL = 10'h00C;
  localparam logic [9:0] ZVP_VS_LINES = 10'h002;
  localparam logic [9:0] ZVP_V_START = 10'h003;
  localparam logic [9:0] ZVP_V_ACTIVE = 10'h008;
  localparam logic [7:0] ZVP_BLANK = 8'h00;
  // ----------------------------------------------------------------
  // audio: phase accumulator ticks at 512 x sample rate
  // ----------------------------------------------------------------
  localparam int ZVP_ACC_W = 24;
  localparam longint ZVP_FS_32K = 32000;
  localparam longint ZVP_FS_44K = 44100;
  localparam longint ZVP_FS_48K = 48000;
  localparam logic [1:0] ZVP_RATE_32K = 2'h0;
  localparam logic [1:0] ZVP_RATE_44K = 2'h1;
  localparam logic [1:0] ZVP_RATE_48K = 2'h2;
  localparam logic [ZVP_ACC_W-1:0] ZVP_INC_32K = ZVP_ACC_W'((512 * ZVP_FS_32K * (64'd1 << ZVP_ACC_W)) / ZVP_CLK_HZ);
  localparam logic [ZVP_ACC_W-1:0] ZVP_INC_44K = ZVP_ACC_W'((512 * ZVP_FS_44K * (64'd1 << ZVP_ACC_W)) / ZVP_CLK_HZ);
  localparam logic [ZVP_ACC_W-1:0] ZVP_INC_48K = ZVP_ACC_W'((512 * ZVP_FS_48K * (64'd1 << ZVP_ACC_W)) / ZVP_CLK_HZ);
  localparam logic [4:0] ZVP_AUD_BITS = 5'h10; // bits per channel word
  // ----------------------------------------------------------------
  // restricted i/o window
  // ----------------------------------------------------------------
  localparam logic [5:0] ZVP_IO_PORTS = 6'h20;
endpackage

/* verification/zvp_port_model.sv */
// receiving port model: counts pixels per line and lines per frame, decodes i2s words
`timescale 1ns/1ps
module zvp_port_model (
  input wire logic clock_in,
  input wire logic pixel_clock_in,
  input wire logic line_reference_in,
  input wire logic frame_sync_in,
  input wire logic i2s_lr_in,
  input wire logic i2s_data_in,
  input wire logic i2s_bit_clock_in,
  output logic [7:0] line_pixels_out,
  output logic [7:0] frame_lines_out,
  output logic [15:0] left_word_out,
  output logic [15:0] right_word_out
);
  logic pclk_q = 1'b0, lref_q = 1'b0, fs_q = 1'b0, sclk_q = 1'b0, lr_q = 1'b0;
  logic [7:0] pix_q = 8'h00;
  logic [7:0] lines_q = 8'h00;
  logic [5:0] slot_q = 6'h00;
  logic [15:0] shift_q = 16'h0000;
  // edge detection on the system clock, capture on pixel and bit clock rises
  always @(posedge clock_in) begin
    pclk_q <= pixel_clock_in;
    lref_q <= line_reference_in;
    fs_q <= frame_sync_in;
    sclk_q <= i2s_bit_clock_in;
    if (pixel_clock_in && !pclk_q && line_reference_in) begin
      pix_q <= pix_q + 8'h01;
    end
    if (lref_q && !line_reference_in) begin
      line_pixels_out <= pix_q;
      pix_q <= 8'h00;
      lines_q <= lines_q + 8'h01;
    end
    if (frame_sync_in && !fs_q) begin
      frame_lines_out <= lines_q;
      lines_q <= 8'h00;
    end
    if (i2s_bit_clock_in && !sclk_q) begin
      lr_q <= i2s_lr_in;
      slot_q <= (i2s_lr_in != lr_q) ? 6'h01 : slot_q + 6'h01;
      if (i2s_lr_in != lr_q && !lr_q) begin
        left_word_out <= shift_q;
      end
      if (i2s_lr_in != lr_q && lr_q) begin
        right_word_out <= shift_q;
      end
      // msb arrives one bit clock after the select change
      if (i2s_lr_in == lr_q && slot_q >= 6'h01 && slot_q <= 6'h10) begin
        shift_q <= {shift_q[14:0], i2s_data_in};
      end
    end
  end
endmodule // zvp_port_model

/* verification/tb_top.sv */
// testbench for the card-side zoomed video port driver
`timescale 1ns/1ps
module tb_top;
  import zvp_pkg::*;
  logic clock_in, rst_in, mm_mode_in, io_strobe_in, io_mem_in;
  logic [7:0] luma_in, cb_in, cr_in, luma_out, chroma_out, line_pixels, frame_lines;
  logic [1:0] rate_sel_in;
  logic [15:0] audio_left_in, audio_right_in, left_word, right_word;
  logic [4:0] io_addr_in, io_port_out;
  logic pixel_clock_out, line_reference_out, frame_sync_out, video_oe_out, pixel_take_out;
  logic i2s_lr_out, i2s_data_out, i2s_bit_clock_out, audio_take_out, io_hit_out;
  logic res_hi, res_hi_oe, res_lo, res_lo_oe, mclk;
  int bad_count = 0;
  int check_count = 0;
  longint fsv [4] = '{ZVP_FS_32K, ZVP_FS_44K, ZVP_FS_48K, ZVP_FS_48K};
  zvp_card_port dut (.clock_in(clock_in), .rst_in(rst_in), .mm_mode_in(mm_mode_in), .luma_in(luma_in),
    .cb_in(cb_in), .cr_in(cr_in), .rate_sel_in(rate_sel_in), .audio_left_in(audio_left_in),
    .audio_right_in(audio_right_in), .io_strobe_in(io_strobe_in), .io_mem_in(io_mem_in),
    .io_addr_in(io_addr_in), .pixel_clock_out(pixel_clock_out), .line_reference_out(line_reference_out),
    .frame_sync_out(frame_sync_out), .luma_out(luma_out), .chroma_out(chroma_out),
    .video_oe_out(video_oe_out), .pixel_take_out(pixel_take_out), .i2s_lr_out(i2s_lr_out),
    .i2s_data_out(i2s_data_out), .i2s_bit_clock_out(i2s_bit_clock_out), .i2s_master_clock_out(mclk),
    .audio_take_out(audio_take_out), .reserved_line_hi_out(res_hi), .reserved_line_hi_oe_out(res_hi_oe),
    .reserved_line_lo_out(res_lo), .reserved_line_lo_oe_out(res_lo_oe), .io_hit_out(io_hit_out),
    .io_port_out(io_port_out));
  zvp_port_model model (.clock_in(clock_in), .pixel_clock_in(pixel_clock_out),
    .line_reference_in(line_reference_out), .frame_sync_in(frame_sync_out), .i2s_lr_in(i2s_lr_out),
    .i2s_data_in(i2s_data_out), .i2s_bit_clock_in(i2s_bit_clock_out), .line_pixels_out(line_pixels),
    .frame_lines_out(frame_lines), .left_word_out(left_word), .right_word_out(right_word));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return pixel_take_out;
      1: return audio_take_out;
      default: return frame_sync_out;
    endcase
  endfunction
  // bounded wait for a signal, n returns the edges spent
  task automatic wait_for(input int w, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (sig(w) !== 1'b1 && n < lim);
    if (sig(w) !== 1'b1) begin
      bad_count++;
      $display("Error wait %0d expected 1 seen timeout", w);
      report_and_stop();
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_idle();
    repeat (60) @(posedge clock_in);
    check("idle lines", 0, {video_oe_out, pixel_clock_out, line_reference_out, i2s_bit_clock_out});
  endtask
  task automatic test_video();
    int n;
    int hi;
    mm_mode_in <= 1'b1;
    luma_in <= 8'h3C;
    for (int i = 0; i < 24; i++) begin
      wait_for(0, 2000, n);
      check("luma", 32'(8'h3C + 8'(i)), 32'(luma_out));
      check("chroma", (i % 2 == 0) ? 32'h51 : 32'h6E, 32'(chroma_out));
      luma_in <= 8'h3C + 8'(i) + 8'h01;
    end
    // let the line end so the model has counted it
    repeat (6) @(posedge clock_in);
    check("video oe", 1, 32'(video_oe_out));
    check("reserved", 0, {res_hi, res_hi_oe, res_lo, res_lo_oe});
    check("line pixels", 32'(ZVP_H_ACTIVE), 32'(line_pixels));
    wait_for(2, 3000, n);
    hi = 1;
    while (frame_sync_out === 1'b1 && hi < 2000) begin
      @(posedge clock_in);
      hi += (frame_sync_out === 1'b1) ? 1 : 0;
    end
    check("sync width", 32'(ZVP_VS_LINES * ZVP_H_TOTAL * (1 << ZVP_PIX_PH_W)), 32'(hi));
    check("frame lines", 32'(ZVP_V_ACTIVE), 32'(frame_lines));
  endtask
  task automatic io_case(input logic mm, input logic mem, input logic [4:0] a, input logic hit);
    mm_mode_in <= mm;
    io_mem_in <= mem;
    io_addr_in <= a;
    io_strobe_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    check("io early", 0, 32'(io_hit_out));
    @(posedge clock_in);
    check("io hit", 32'(hit), 32'(io_hit_out));
    check("io port", 32'(a), 32'(io_port_out));
    io_strobe_in <= 1'b0;
    repeat (5) @(posedge clock_in);
    check("io idle", 0, 32'(io_hit_out));
  endtask
  task automatic test_audio(input int r);
    int n;
    int m;
    int k;
    logic prev;
    longint p;
    rate_sel_in <= 2'(r);
    audio_left_in <= 16'hC3A1 ^ 16'(r);
    repeat (3) wait_for(1, 3000, n);
    p = ZVP_CLK_HZ / fsv[r];
    check("audio period", 1, 32'(n >= p - 2 && n <= p + 2));
    check("left word", 32'(16'hC3A1 ^ 16'(r)), 32'(left_word));
    check("right word", 32'h5E27, 32'(right_word));
    // master clock rises over one stereo frame
    m = 0;
    k = 0;
    prev = mclk;
    do begin
      @(posedge clock_in);
      k++;
      m += (mclk === 1'b1 && prev === 1'b0) ? 1 : 0;
      prev = mclk;
    end while (audio_take_out !== 1'b1 && k < 3000);
    if (audio_take_out !== 1'b1) begin
      bad_count++;
      $display("Error mclk wait expected 1 seen timeout");
      report_and_stop();
    end
    check("mclk per frame", 32'h100, 32'(m));
  endtask
  // ------------------------------------------------------------
  // clock and main sequence
  // ------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  initial begin
    rst_in = 1'b1;
    mm_mode_in = 1'b0;
    {io_strobe_in, io_mem_in, io_addr_in, rate_sel_in} = '0;
    {luma_in, cb_in, cr_in} = {8'h3C, 8'h51, 8'h6E};
    {audio_left_in, audio_right_in} = {16'hC3A1, 16'h5E27};
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    test_idle();
    test_video();
    io_case(1'b1, 1'b0, 5'h00, 1'b1);
    io_case(1'b1, 1'b0, 5'h1F, 1'b1);
    io_case(1'b1, 1'b1, 5'h0A, 1'b0);
    io_case(1'b0, 1'b0, 5'h0A, 1'b0);
    mm_mode_in <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      test_audio(r);
    end
    report_and_stop();
  end
endmodule // tb_top
